// >>> core/amb_ctrl.sv
// Audio matrix board controller: host mailbox, matrix driver, scanner, keyboard, level and tone.
`timescale 1ns/1ps

// How it works
// - decode only while read or write strobe
// - wait only on decode plus controller access
// - ready line low stalls, else high
// - host data path is eight bits
// - window base set by switches, D000
// - poll command flag, fetch and execute
// - write results, then interrupt the host
// - drive coordinates and state, then strobe
// - three-bit X and Y, one closes
// - matrix lines quiet unless update needed
// - invert inputs, scanner flags any change
// - compare scan with stored groups, report changes
// - inverted keyboard serial at 9600 baud
// - copy level readings into the mailbox
// - tone divides the divided clock programmably
// - divide by eight scan, four tone
// - power-on reset waits a fixed delay
// - startup reads scanner several times
// - startup clears mailbox, writes signature
// - startup opens all crosspoints if powered
// - after init, poll and service everything
// - on far power loss wait, clear, restore
module amb_ctrl
  import amb_pkg::*;
#(
  parameter int unsigned KBD_BIT_CYC_P = KBD_BIT_CYC
) (
  input  wire logic          ref_clk,
  input  wire logic          rstn,
  input  wire logic [11:0]   paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   pwdata,
  output amb_apb_rsp_s       apb_rsp,
  input  wire logic [19:0]   host_addr,
  input  wire logic          host_rd_n,
  input  wire logic          host_wr_n,
  input  wire logic [7:0]    host_wdata,
  output logic      [7:0]    host_rdata,
  output logic               host_data_oe,
  output logic               host_ready,
  output logic               host_irq,
  input  wire logic [7:0]    base_sw,
  output amb_xp_s            xp,
  input  wire logic [IN_W-1:0] ext_in_raw,
  input  wire logic          power_ind_raw,
  input  wire logic          kbd_line,
  input  wire logic [7:0]    level_data,
  input  wire logic          level_valid,
  output logic               tone_out
);

  if (KBD_BIT_CYC_P < 4 || KBD_BIT_CYC_P > 65535) begin : g_chk
    $error("KBD_BIT_CYC_P out of range");
  end

  typedef struct packed {
    amb_state_e  st;
    logic [15:0] por_cnt;
    logic [8:0]  cnt;
    logic [2:0]  div_cnt;
    logic [24:0] scan_cur;
    logic        scan_irq;
    logic [24:0] snap;
    logic [24:0] prev;
    amb_xp_s     xp;
    logic        single;
    logic        pass;
    logic        restore_req;
    logic [7:0]  code;
    logic [31:0] args;
    logic [7:0]  res;
    logic [7:0]  host_rdata;
    logic        host_oe;
    logic        host_rdy;
    logic        host_irq;
    logic [7:0]  tone_div;
    logic        tone_en;
    logic [7:0]  tone_cnt;
    logic        tone_out;
    logic        kb_busy;
    logic [15:0] kb_cnt;
    logic [3:0]  kb_bit;
    logic [7:0]  kb_sh;
    logic [7:0]  kb_byte;
    logic        kb_new;
    logic [7:0]  lvl_byte;
    logic        lvl_pend;
    amb_apb_rsp_s apb;
  } amb_st_s;

  localparam logic [15:0] BIT_LAST  = 16'(KBD_BIT_CYC_P - 1);
  localparam logic [15:0] HALF_LAST = 16'((KBD_BIT_CYC_P / 2) - 1);
  localparam logic [15:0] POR_LAST  = 16'(POR_CYC - 1);

  function automatic logic [7:0] grp(input logic [24:0] v, input logic [1:0] i);
    logic [7:0] r;
    r = 8'h00;
    unique case (i)
      2'h0: r = v[7:0];
      2'h1: r = v[15:8];
      2'h2: r = v[23:16];
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  logic [1:0]  rst_sync;
  logic        rst_n_s;
  amb_st_s     s;
  amb_st_s     n;
  logic [7:0]  mb_mem [256];
  logic        xp_map [512];
  logic        cw_en;
  logic [7:0]  cw_addr;
  logic [7:0]  cw_data;
  logic        cr_en;
  logic [7:0]  cr_addr;
  logic [7:0]  cr_data;
  logic        xw_en;
  logic [8:0]  xw_idx;
  logic        xw_val;
  logic        host_sel;
  logic        ctrl_acc;
  logic        hw_en;
  logic        scan_tick;
  logic [24:0] scan_in;
  logic        kb_rx;
  logic [7:0]  base_hi;
  logic [8:0]  xp_idx;
  logic        kb_done;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n_s = rst_sync[1];

  always_comb begin
    n       = s;
    cw_en   = 1'b0;
    cw_addr = 8'h00;
    cw_data = 8'h00;
    cr_en   = 1'b0;
    cr_addr = 8'h00;
    xw_en   = 1'b0;
    xw_idx  = 9'h000;
    xw_val  = 1'b0;
    xp_idx  = 9'h000;
    kb_done = 1'b0;
    n.div_cnt = s.div_cnt + 3'h1;
    scan_tick = (s.div_cnt == DIV_SCAN_LAST);
    scan_in = ~{power_ind_raw, ext_in_raw};
    if (scan_tick) begin
      n.scan_cur = scan_in;
      if (scan_in != s.scan_cur) begin
        n.scan_irq = 1'b1;
      end
    end
    if (!s.tone_en) begin
      n.tone_out = 1'b0;
      n.tone_cnt = 8'h00;
    end else if (s.div_cnt[1:0] == DIV_TONE_LAST) begin
      if (s.tone_cnt >= s.tone_div) begin
        n.tone_cnt = 8'h00;
        n.tone_out = ~s.tone_out;
      end else begin
        n.tone_cnt = s.tone_cnt + 8'h01;
      end
    end
    kb_rx = ~kbd_line;
    if (!s.kb_busy) begin
      if (!kb_rx) begin
        n.kb_busy = 1'b1;
        n.kb_cnt  = 16'h0000;
        n.kb_bit  = 4'h0;
      end
    end else if ((s.kb_bit == 4'h0) ? (s.kb_cnt == HALF_LAST) : (s.kb_cnt == BIT_LAST)) begin
      n.kb_cnt = 16'h0000;
      n.kb_bit = s.kb_bit + 4'h1;
      if (s.kb_bit == 4'h0) begin
        n.kb_busy = ~kb_rx;
      end else if (s.kb_bit == 4'h9) begin
        n.kb_busy = 1'b0;
        if (kb_rx) begin
          n.kb_byte = s.kb_sh;
          n.kb_new  = 1'b1;
          kb_done   = 1'b1;
        end
      end else begin
        n.kb_sh = {kb_rx, s.kb_sh[7:1]};
      end
    end else begin
      n.kb_cnt = s.kb_cnt + 16'h0001;
    end
    if (level_valid) begin
      n.lvl_byte = level_data;
    end
    unique case (s.st)
      ST_POR: begin
        n.por_cnt = s.por_cnt + 16'h0001;
        if (s.por_cnt == POR_LAST) begin
          n.st  = ST_SCAN_INI;
          n.cnt = 9'h000;
        end
      end
      ST_SCAN_INI: begin
        if (scan_tick) begin
          n.prev     = scan_in;
          n.scan_irq = 1'b0;
          n.cnt      = s.cnt + 9'h001;
          if (s.cnt == 9'(SCAN_READS - 1)) begin
            n.st  = ST_MEM_CLR;
            n.cnt = 9'h000;
          end
        end
      end
      ST_MEM_CLR: begin
        cw_en   = 1'b1;
        cw_addr = s.cnt[7:0];
        xw_en   = 1'b1;
        xw_idx  = s.cnt;
        n.cnt   = s.cnt + 9'h001;
        if (s.cnt == XP_LAST) begin
          n.st  = ST_SIG_WR;
          n.cnt = 9'h000;
        end
      end
      ST_SIG_WR: begin
        cw_en   = 1'b1;
        cw_addr = MB_SIG + s.cnt[7:0];
        cw_data = s.cnt[0] ? SIG_BYTE1 : SIG_BYTE0;
        n.cnt   = s.cnt + 9'h001;
        if (s.cnt[0]) begin
          n.st = ST_PWR_CHK;
        end
      end
      ST_PWR_CHK: begin
        n.cnt         = 9'h000;
        n.single      = 1'b0;
        n.pass        = 1'b0;
        n.restore_req = 1'b0;
        n.st          = s.prev[PWR_BIT] ? ST_XP_DRIVE : ST_IDLE;
      end
      ST_IDLE: begin
        n.cnt = 9'h000;
        if (s.scan_irq) begin
          n.snap     = s.scan_cur;
          n.scan_irq = scan_tick && (scan_in != s.scan_cur);
          n.st       = ST_SCAN_SVC;
        end else if (s.kb_new) begin
          n.st = ST_KEY_WR;
        end else if (s.lvl_pend) begin
          n.st = ST_LVL_WR;
        end else begin
          n.st = ST_CMD_POLL;
        end
      end
      ST_SCAN_SVC: begin
        cw_en = 1'b1;
        if (s.cnt < 9'h003) begin
          cw_addr = MB_IN_STATE + s.cnt[7:0];
          cw_data = grp(s.snap, s.cnt[1:0]);
        end else begin
          cw_addr = MB_IN_CHANGE + s.cnt[7:0] - 8'h03;
          cw_data = grp(s.snap ^ s.prev, 2'(s.cnt - 9'h003));
        end
        n.cnt = s.cnt + 9'h001;
        if (s.cnt == 9'h005) begin
          n.prev = s.snap;
          n.st   = (s.prev[PWR_BIT] && !s.snap[PWR_BIT]) ? ST_PWR_WAIT : ST_IDLE;
        end
      end
      ST_KEY_WR: begin
        cw_en   = 1'b1;
        cw_addr = s.cnt[0] ? MB_KEY_FLAG : MB_KEY;
        cw_data = s.cnt[0] ? 8'h01 : s.kb_byte;
        n.cnt   = s.cnt + 9'h001;
        if (s.cnt[0]) begin
          n.kb_new = kb_done;
          n.st     = ST_IDLE;
        end
      end
      ST_LVL_WR: begin
        cw_en      = 1'b1;
        cw_addr    = MB_LEVEL;
        cw_data    = s.lvl_byte;
        n.lvl_pend = 1'b0;
        n.st       = ST_IDLE;
      end
      ST_CMD_POLL: begin
        cr_en   = 1'b1;
        cr_addr = MB_CMD_FLAG;
        n.code  = cr_data;
        n.st    = (cr_data != 8'h00) ? ST_CMD_ARGS : ST_IDLE;
      end
      ST_CMD_ARGS: begin
        cr_en   = 1'b1;
        cr_addr = MB_CMD_ARG + s.cnt[7:0];
        n.args  = {cr_data, s.args[31:8]};
        n.cnt   = s.cnt + 9'h001;
        if (s.cnt == 9'h003) begin
          n.st = ST_CMD_EXEC;
        end
      end
      ST_CMD_EXEC: begin
        n.res = RES_BAD;
        n.st  = ST_RESULT;
        n.cnt = 9'h000;
        if (s.code == CMD_XPOINT) begin
          if (s.args[7:3] == 5'h00 && s.args[15:11] == 5'h00 && s.args[23:19] == 5'h00
              && s.args[31:25] == 7'h00) begin
            n.res    = RES_OK;
            n.single = 1'b1;
            n.pass   = 1'b1;
            n.st     = ST_XP_DRIVE;
            xw_en    = 1'b1;
            xw_idx   = {s.args[2:0], s.args[10:8], s.args[18:16]};
            xw_val   = s.args[24];
          end
        end else if (s.code == CMD_TONE) begin
          n.res      = RES_OK;
          n.tone_div = s.args[7:0];
          n.tone_en  = s.args[8];
        end
      end
      ST_XP_DRIVE: begin
        xp_idx = s.single ? {s.args[2:0], s.args[10:8], s.args[18:16]} : s.cnt;
        if (!s.single && s.pass && !xp_map[s.cnt]) begin
          n.st = ST_XP_ADV;
        end else begin
          n.xp.chip = xp_idx[8:6];
          n.xp.x    = xp_idx[5:3];
          n.xp.y    = xp_idx[2:0];
          n.xp.on   = s.pass && (s.single ? s.args[24] : 1'b1);
          n.st      = ST_XP_STB;
        end
      end
      ST_XP_STB: begin
        n.xp.stb = 1'b1;
        n.st     = ST_XP_ADV;
      end
      ST_XP_ADV: begin
        n.xp.stb = 1'b0;
        n.cnt    = s.cnt + 9'h001;
        if (s.single) begin
          n.single = 1'b0;
          n.cnt    = 9'h000;
          n.st     = ST_RESULT;
        end else if (s.cnt != XP_LAST) begin
          n.st = ST_XP_DRIVE;
        end else if (s.restore_req && !s.pass) begin
          n.pass = 1'b1;
          n.st   = ST_XP_DRIVE;
        end else begin
          n.restore_req = 1'b0;
          n.st          = ST_IDLE;
        end
      end
      ST_RESULT: begin
        cw_en   = 1'b1;
        cw_addr = s.cnt[0] ? MB_CMD_FLAG : MB_RESULT;
        cw_data = s.cnt[0] ? 8'h00 : s.res;
        n.cnt   = s.cnt + 9'h001;
        if (s.cnt[0]) begin
          n.host_irq = 1'b1;
          n.st       = ST_IDLE;
        end
      end
      ST_PWR_WAIT: begin
        if (s.scan_cur[PWR_BIT]) begin
          n.prev[PWR_BIT] = 1'b1;
          n.cnt           = 9'h000;
          n.single        = 1'b0;
          n.pass          = 1'b0;
          n.restore_req   = 1'b1;
          n.st            = ST_XP_DRIVE;
        end
      end
      default: n.st = ST_POR;
    endcase
    if (level_valid) begin
      n.lvl_pend = 1'b1;
    end
    base_hi  = base_sw ^ ~HOST_BASE_ALL_ON;
    host_sel = (!host_rd_n || !host_wr_n) && (host_addr[19:12] == base_hi);
    ctrl_acc = cw_en || cr_en;
    n.host_rdy = !(host_sel && ctrl_acc);
    hw_en = host_sel && !host_wr_n && !ctrl_acc;
    n.host_oe = host_sel && !host_rd_n;
    if (host_sel && !host_rd_n && !ctrl_acc) begin
      n.host_rdata = mb_mem[host_addr[7:0]];
      if (host_addr[7:0] == MB_RESULT && s.st != ST_RESULT) begin
        n.host_irq = 1'b0;
      end
    end
    n.apb.pready  = psel && !penable;
    n.apb.pslverr = 1'b0;
    if (psel && !penable) begin
      n.apb.pslverr = !(paddr == REG_STATUS || paddr == REG_TONE || paddr == REG_LEVEL);
      unique case (paddr)
        REG_STATUS: n.apb.prdata = {24'h000000, s.st, s.prev[PWR_BIT], s.scan_irq, s.host_irq};
        REG_TONE:   n.apb.prdata = {23'h000000, s.tone_en, s.tone_div};
        REG_LEVEL:  n.apb.prdata = {24'h000000, s.lvl_byte};
        default:    n.apb.prdata = 32'h00000000;
      endcase
    end
    if (psel && penable && s.apb.pready && pwrite && paddr == REG_TONE) begin
      n.tone_div = pwdata[7:0];
      n.tone_en  = pwdata[8];
    end
  end

  assign cr_data = mb_mem[cr_addr];

  always_ff @(posedge ref_clk) begin
    if (cw_en) begin
      mb_mem[cw_addr] <= cw_data;
    end else if (hw_en) begin
      mb_mem[host_addr[7:0]] <= host_wdata;
    end
    if (xw_en) begin
      xp_map[xw_idx] <= xw_val;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      s          <= '0;
      s.st       <= ST_POR;
      s.host_rdy <= 1'b1;
      s.tone_div <= TONE_DIV_RST;
    end else begin
      s <= n;
    end
  end

  assign xp           = s.xp;
  assign apb_rsp      = s.apb;
  assign host_rdata   = s.host_rdata;
  assign host_data_oe = s.host_oe;
  assign host_ready   = s.host_rdy;
  assign host_irq     = s.host_irq;
  assign tone_out     = s.tone_out;

endmodule

// >>> include/amb_pkg.sv
// Constants, encodings and carrier types for the audio matrix board controller.
package amb_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned POR_TIME_US   = 10;
  localparam int unsigned POR_CYC       = POR_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned KBD_BAUD      = 9600;
  localparam int unsigned KBD_BIT_CYC   = CLK_HZ / KBD_BAUD;
  localparam int unsigned SCAN_READS    = 4;
  localparam logic [2:0]  DIV_SCAN_LAST = 3'h7;
  localparam logic [1:0]  DIV_TONE_LAST = 2'h3;
  localparam logic [8:0]  XP_LAST       = 9'h1ff;
  localparam int unsigned IN_W          = 24;
  localparam int unsigned PWR_BIT       = 24;
  localparam logic [7:0]  HOST_BASE_ALL_ON = 8'hd0;
  // Mailbox layout.
  localparam logic [7:0]  MB_SIG        = 8'h00;
  localparam logic [7:0]  MB_CMD_FLAG   = 8'h10;
  localparam logic [7:0]  MB_CMD_ARG    = 8'h11;
  localparam logic [7:0]  MB_RESULT     = 8'h20;
  localparam logic [7:0]  MB_LEVEL      = 8'h30;
  localparam logic [7:0]  MB_KEY        = 8'h31;
  localparam logic [7:0]  MB_KEY_FLAG   = 8'h32;
  localparam logic [7:0]  MB_IN_STATE   = 8'h40;
  localparam logic [7:0]  MB_IN_CHANGE  = 8'h43;
  // Signature bytes; the values are arbitrary.
  localparam logic [7:0]  SIG_BYTE0     = 8'h5a;
  localparam logic [7:0]  SIG_BYTE1     = 8'h01;
  localparam logic [7:0]  CMD_XPOINT    = 8'h01;
  localparam logic [7:0]  CMD_TONE      = 8'h02;
  localparam logic [7:0]  RES_OK        = 8'h80;
  localparam logic [7:0]  RES_BAD       = 8'h81;
  // APB register byte offsets.
  localparam logic [11:0] REG_STATUS    = 12'h000;
  localparam logic [11:0] REG_TONE      = 12'h004;
  localparam logic [11:0] REG_LEVEL     = 12'h008;
  localparam logic [7:0]  TONE_DIV_RST  = 8'h10;

  typedef enum logic [4:0] {
    ST_POR      = 5'h00,
    ST_SCAN_INI = 5'h01,
    ST_MEM_CLR  = 5'h02,
    ST_SIG_WR   = 5'h03,
    ST_PWR_CHK  = 5'h04,
    ST_IDLE     = 5'h05,
    ST_SCAN_SVC = 5'h06,
    ST_KEY_WR   = 5'h07,
    ST_LVL_WR   = 5'h08,
    ST_CMD_POLL = 5'h09,
    ST_CMD_ARGS = 5'h0a,
    ST_CMD_EXEC = 5'h0b,
    ST_XP_DRIVE = 5'h0c,
    ST_XP_STB   = 5'h0d,
    ST_XP_ADV   = 5'h0e,
    ST_RESULT   = 5'h0f,
    ST_PWR_WAIT = 5'h10
  } amb_state_e;

  typedef struct packed {
    logic [2:0] chip;
    logic [2:0] x;
    logic [2:0] y;
    logic       on;
    logic       stb;
  } amb_xp_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } amb_apb_rsp_s;
endpackage

// >>> tb/amb_ctrl_checker.sv
// Port assertions for the audio matrix board controller.
`timescale 1ns/1ps
module amb_ctrl_checker
  import amb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic host_data_oe,
  input wire logic host_ready,
  input wire logic host_irq,
  input amb_xp_s   xp,
  input wire logic tone_out
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  AST_NO_DECODE_OE: assert property (host_rd_n |=> !host_data_oe)
    else $error("host data driven without read strobe");
  AST_NO_IDLE_WAIT: assert property (host_rd_n && host_wr_n |=> host_ready)
    else $error("wait raised without host strobe");
  AST_WAIT_BOUNDED: assert property (!host_ready |-> ##[1:8] host_ready)
    else $error("wait not released in time");
  AST_STB_PULSE: assert property (xp.stb |=> !xp.stb)
    else $error("strobe longer than one cycle");
  AST_LINES_BEFORE_STB: assert property (xp.stb |-> $stable({xp.chip, xp.x, xp.y, xp.on}))
    else $error("matrix lines moved during strobe");
  AST_LINES_QUIET: assert property ($changed({xp.chip, xp.x, xp.y, xp.on}) |-> ##[1:2] xp.stb)
    else $error("matrix lines moved without strobe");
  AST_TONE_GAP: assert property ($changed(tone_out) |=> (!$changed(tone_out))[*3])
    else $error("tone edge spacing below four cycles");
  AST_IRQ_HOLD: assert property (host_irq && host_rd_n |=> host_irq)
    else $error("host interrupt dropped without host read");

  cover property (xp.stb && xp.on);
  cover property (!host_ready);
  cover property ($rose(host_irq));
endmodule

bind amb_ctrl amb_ctrl_checker CHK (
  .ref_clk     (ref_clk),
  .rstn        (rstn),
  .host_rd_n   (host_rd_n),
  .host_wr_n   (host_wr_n),
  .host_data_oe(host_data_oe),
  .host_ready  (host_ready),
  .host_irq    (host_irq),
  .xp          (xp),
  .tone_out    (tone_out)
);

// >>> tb/amb_host_model.sv
// Host bus master model that reaches the mailbox window.
`timescale 1ns/1ps
module amb_host_model
  import amb_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic [7:0]  host_rdata,
  input  wire logic        host_data_oe,
  input  wire logic        host_ready,
  output logic      [19:0] host_addr,
  output logic             host_rd_n,
  output logic             host_wr_n,
  output logic      [7:0]  host_wdata
);
  initial begin
    host_addr  = 20'h00000;
    host_rd_n  = 1'b1;
    host_wr_n  = 1'b1;
    host_wdata = 8'h00;
  end

  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    q = 8'hxx;
    host_addr  <= {HOST_BASE_ALL_ON, 4'h0, a};
    host_wdata <= d;
    host_rd_n  <= w;
    host_wr_n  <= !w;
    @(posedge ref_clk);
    do begin
      @(posedge ref_clk);
      n++;
    end while (!(host_ready === 1'b1 && (w || host_data_oe === 1'b1)) && n < 60);
    if (n < 60)
      q = host_rdata;
    host_rd_n  <= 1'b1;
    host_wr_n  <= 1'b1;
    host_wdata <= ~d;
    @(posedge ref_clk);
  endtask
endmodule

// >>> tb/amb_ctrl_tb.sv
// Self-checking testbench for the audio matrix board controller.
`timescale 1ns/1ps
module amb_ctrl_tb
  import amb_pkg::*;
();
  typedef struct packed {
    logic        w;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic        e;
  } amb_row_s;

  logic             ref_clk = 1'b0;
  logic             rstn = 1'b0;
  logic [11:0]      paddr = 12'h000;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [31:0]      pwdata = 32'h0;
  amb_apb_rsp_s     apb_rsp;
  logic [19:0]      host_addr;
  logic             host_rd_n;
  logic             host_wr_n;
  logic [7:0]       host_wdata;
  logic [7:0]       host_rdata;
  logic             host_data_oe;
  logic             host_ready;
  logic             host_irq;
  amb_xp_s          xp;
  logic [IN_W-1:0]  ext_in_raw = '1;
  logic             power_ind_raw = 1'b1;
  logic             kbd_line = 1'b0;
  logic [7:0]       level_data = 8'h00;
  logic             level_valid = 1'b0;
  logic             tone_out;
  logic [7:0]       q8;
  logic [31:0]      q32;
  logic             e1;
  amb_xp_s          last_xp = '0;
  int               n_on = 0;
  int               n_off = 0;
  int               fails = 0;
  int               comparisons = 0;
  int               g;
  amb_row_s         rows [5] = '{
    '{1'b0, REG_TONE, 32'h0, {24'h0, TONE_DIV_RST}, 1'b0},
    '{1'b1, REG_TONE, 32'h100, 32'h0, 1'b0},
    '{1'b0, REG_TONE, 32'h0, 32'h100, 1'b0},
    '{1'b0, 12'h00c, 32'h0, 32'h0, 1'b1},
    '{1'b1, 12'h010, 32'h5, 32'h0, 1'b1}
  };

  always #5 ref_clk = ~ref_clk;

  amb_ctrl #(.KBD_BIT_CYC_P(16)) DUT (
    .ref_clk(ref_clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .apb_rsp(apb_rsp), .host_addr(host_addr),
    .host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_data_oe(host_data_oe), .host_ready(host_ready),
    .host_irq(host_irq), .base_sw(8'hff), .xp(xp), .ext_in_raw(ext_in_raw),
    .power_ind_raw(power_ind_raw), .kbd_line(kbd_line), .level_data(level_data),
    .level_valid(level_valid), .tone_out(tone_out)
  );

  amb_host_model HOST (
    .ref_clk(ref_clk), .host_rdata(host_rdata), .host_data_oe(host_data_oe),
    .host_ready(host_ready), .host_addr(host_addr), .host_rd_n(host_rd_n),
    .host_wr_n(host_wr_n), .host_wdata(host_wdata)
  );

  always @(posedge ref_clk) begin
    if (xp.stb === 1'b1) begin
      last_xp <= xp;
      if (xp.on)
        n_on <= n_on + 1;
      else
        n_off <= n_off + 1;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    q32 = apb_rsp.prdata;
    e1 = apb_rsp.pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic poll(input logic [7:0] a, input logic [7:0] e);
    for (int i = 0; i < 1000; i++) begin
      HOST.acc(1'b0, a, 8'h00, q8);
      if (q8 === e)
        break;
    end
  endtask

  task automatic cmd(input logic [7:0] x);
    HOST.acc(1'b1, MB_CMD_ARG, 8'h03, q8);
    HOST.acc(1'b1, MB_CMD_ARG + 8'h01, x, q8);
    HOST.acc(1'b1, MB_CMD_ARG + 8'h02, 8'h07, q8);
    HOST.acc(1'b1, MB_CMD_ARG + 8'h03, 8'h01, q8);
    HOST.acc(1'b1, MB_CMD_FLAG, CMD_XPOINT, q8);
    for (int i = 0; i < 300 && host_irq !== 1'b1; i++)
      @(posedge ref_clk);
    HOST.acc(1'b0, MB_RESULT, 8'h00, q8);
  endtask

  task automatic gap(output int n);
    logic t0;
    for (int k = 0; k < 2; k++) begin
      t0 = tone_out;
      n = 0;
      while (tone_out === t0 && n < 100) begin
        @(posedge ref_clk);
        n++;
      end
    end
  endtask

  task automatic kbd(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      kbd_line <= ~f[i];
      repeat (16) @(posedge ref_clk);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    report_and_stop();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    chk({31'h0, host_ready}, 32'h1);
    chk({21'h0, xp}, 32'h0);
    rstn <= 1'b1;
    repeat (POR_CYC + 600) @(posedge ref_clk);
    $display("test reset done");
    poll(MB_SIG, SIG_BYTE0);
    chk({24'h0, q8}, {24'h0, SIG_BYTE0});
    HOST.acc(1'b0, MB_SIG + 8'h01, 8'h00, q8);
    chk({24'h0, q8}, {24'h0, SIG_BYTE1});
    $display("test signature done");
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        chk(q32, rows[i].q);
      chk({31'h0, e1}, {31'h0, rows[i].e});
    end
    gap(g);
    chk(g, 32'd4);
    $display("test registers done");
    cmd(8'h05);
    chk({24'h0, q8}, {24'h0, RES_OK});
    chk({21'h0, last_xp}, {21'h0, 3'h3, 3'h5, 3'h7, 1'b1, 1'b1});
    chk({31'h0, host_irq}, 32'h0);
    HOST.acc(1'b0, MB_CMD_FLAG, 8'h00, q8);
    chk({24'h0, q8}, 32'h0);
    g = n_on;
    cmd(8'h08);
    chk({24'h0, q8}, {24'h0, RES_BAD});
    chk(n_on, g);
    $display("test matrix done");
    level_data <= 8'ha7;
    level_valid <= 1'b1;
    @(posedge ref_clk);
    level_valid <= 1'b0;
    poll(MB_LEVEL, 8'ha7);
    chk({24'h0, q8}, 32'ha7);
    ext_in_raw <= 24'hfffffe;
    poll(MB_IN_CHANGE, 8'h01);
    chk({24'h0, q8}, 32'h1);
    HOST.acc(1'b0, MB_IN_STATE, 8'h00, q8);
    chk({24'h0, q8}, 32'h1);
    kbd(8'hc5);
    poll(MB_KEY, 8'hc5);
    chk({24'h0, q8}, 32'hc5);
    HOST.acc(1'b0, MB_KEY_FLAG, 8'h00, q8);
    chk({24'h0, q8}, 32'h1);
    $display("test inputs done");
    power_ind_raw <= 1'b0;
    repeat (200) @(posedge ref_clk);
    n_on = 0;
    n_off = 0;
    power_ind_raw <= 1'b1;
    repeat (50) @(posedge ref_clk);
    power_ind_raw <= 1'b0;
    for (int i = 0; i < 5000 && n_on < 1; i++)
      @(posedge ref_clk);
    repeat (20) @(posedge ref_clk);
    chk(n_off, 32'd512);
    chk(n_on, 32'd1);
    chk({21'h0, last_xp}, {21'h0, 3'h3, 3'h5, 3'h7, 1'b1, 1'b1});
    $display("test power done");
    rstn <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk({20'h0, xp, host_irq}, 32'h0);
    n_on = 0;
    n_off = 0;
    rstn <= 1'b1;
    for (int i = 0; i < 4000 && n_off < 512; i++)
      @(posedge ref_clk);
    repeat (20) @(posedge ref_clk);
    chk(n_off, 32'd512);
    chk(n_on, 32'd0);
    HOST.acc(1'b0, MB_LEVEL, 8'h00, q8);
    chk({24'h0, q8}, 32'h0);
    HOST.acc(1'b0, MB_SIG, 8'h00, q8);
    chk({24'h0, q8}, {24'h0, SIG_BYTE0});
    $display("test restart done");
    report_and_stop();
  end
endmodule
